// >>> chsh_pkg.sv
// Package of constants for the channel update synchronisation and hold-off block.
package chsh_pkg;

  // ***************************************************************
  // Widths of the microprocessor port.
  // ***************************************************************
  localparam int CHSH_ADDR_W = 12;  // Channel page in bits 11:8, offset in bits 7:0.
  localparam int CHSH_DATA_W = 16;  // Data word of the port.
  localparam int CHSH_CNT_W = 16;   // Hold-off counter width.
  localparam int CHSH_NFUNC = 3;    // Start, hop and beam.

  // ***************************************************************
  // External register addresses, taken from address bits 2:0.
  // ***************************************************************
  localparam logic [2:0] CHSH_EXT_MODE = 3'h4;  // Sleep and program bits.
  localparam logic [2:0] CHSH_EXT_SYNC = 3'h5;  // Trigger selects and commands.

  // ***************************************************************
  // Field positions of the external registers.
  // ***************************************************************
  localparam int CHSH_SLEEP_POS = 0;  // Sleep bits, one per channel.
  localparam int CHSH_PROG_POS = 4;   // Program-mode bits, one per channel.
  localparam int CHSH_SEL_POS = 0;    // Trigger-select bits, one per channel.
  localparam int CHSH_CMD_POS = 4;    // Start, hop, beam command bits in that order.

  // ***************************************************************
  // Channel register offsets within a channel page.
  // ***************************************************************
  localparam logic [7:0] CHSH_OFF_START_CNT = 8'h00;  // Start hold-off count.
  localparam logic [7:0] CHSH_OFF_CTRL = 8'h01;       // Channel control.
  localparam logic [7:0] CHSH_OFF_FREQ = 8'h02;       // NCO frequency shadow.
  localparam logic [7:0] CHSH_OFF_FREQ_CNT = 8'h03;   // Frequency hold-off count.
  localparam logic [7:0] CHSH_OFF_PHASE = 8'h04;      // Phase offset shadow.
  localparam logic [7:0] CHSH_OFF_PHASE_CNT = 8'h05;  // Phase hold-off count.
  localparam logic [7:0] CHSH_OFF_MEM = 8'h80;        // First memory word; bit 7 marks memory.

  // ***************************************************************
  // Channel control field positions.
  // ***************************************************************
  localparam int CHSH_CTRL_W = 8;         // Stored width of the control register.
  localparam int CHSH_CTRL_PCLR = 2;      // Clear phase accumulator on sync.
  localparam int CHSH_CTRL_PIN_EN = 3;    // Sync pin enable.
  localparam int CHSH_CTRL_PIN_POS = 5;   // Start, hop, beam on-pin bits in that order.

  // ***************************************************************
  // Reset values.
  // ***************************************************************
  localparam logic [15:0] CHSH_RST_WORD = 16'h0000;  // Counts, shadows and control.
  localparam logic [3:0] CHSH_RST_SLEEP = 4'hF;      // Every channel asleep.
  localparam logic [3:0] CHSH_RST_PROG = 4'h0;       // No channel in program mode.

  // Offset of the hold-off count for function f: 0 start, 1 hop, 2 beam.
  function automatic logic [7:0] chsh_ho_off(input int f);
    case (f)
      0: chsh_ho_off = CHSH_OFF_START_CNT;
      1: chsh_ho_off = CHSH_OFF_FREQ_CNT;
      default: chsh_ho_off = CHSH_OFF_PHASE_CNT;
    endcase
  endfunction

endpackage

// >>> chsh_holdoff.sv
// One hold-off counter that delays a shadowed update by a programmed number of clocks.
`timescale 1ns/1ps
`default_nettype none
module chsh_holdoff #(
  parameter int CNT_W = chsh_pkg::CHSH_CNT_W
) (
  input wire logic clk_i,                 // Master clock.
  input wire logic sys_rst_i,             // Asynchronous reset, active high.
  input wire logic wr_i,                  // Software write of the count.
  input wire logic [CNT_W-1:0] wdata_i,   // Count to store.
  input wire logic trig_i,                // Soft or pin trigger.
  output logic [CNT_W-1:0] count_o,       // Live count for read-back.
  output logic busy_o,                    // Countdown in progress.
  output logic fire_o                     // One-cycle update pulse.
);
  import chsh_pkg::*;

  // ***************************************************************
  // State.
  // ***************************************************************
  typedef enum logic [1:0] {
    CHSH_HO_IDLE = 2'b01,
    CHSH_HO_RUN = 2'b10
  } chsh_ho_st_t;

  typedef struct packed {
    chsh_ho_st_t st;        // Idle or counting.
    logic [CNT_W-1:0] cnt;  // Remaining count.
    logic fire;             // Update pulse.
  } chsh_ho_t;

  chsh_ho_t q;  // Registered state.
  chsh_ho_t d;  // Next state.

  if (CNT_W < 2) begin : g_chk
    $error("Hold-off counter needs at least two bits.");
  end

  // Next-state logic: load while idle, count down once per clock, fire at one.
  always_comb begin
    d = q;
    d.fire = 1'b0;
    case (q.st)
      CHSH_HO_IDLE: begin
        if (wr_i) begin
          d.cnt = wdata_i;
        end
        // A trigger on a count of zero or one updates on the next clock.
        if (trig_i) begin
          if (q.cnt <= CNT_W'(1)) begin
            d.fire = 1'b1;
          end else begin
            d.st = CHSH_HO_RUN;
          end
        end
      end
      CHSH_HO_RUN: begin
        if (q.cnt <= CNT_W'(1)) begin
          // Fired: back to idle with the count left at one, so a later trigger fires on the next clock.
          d.fire = 1'b1;
          d.st = CHSH_HO_IDLE;
        end else begin
          d.cnt = q.cnt - CNT_W'(1);
        end
      end
      default: begin
        d.st = CHSH_HO_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q.st <= CHSH_HO_IDLE;
      q.cnt <= CNT_W'(CHSH_RST_WORD);
      q.fire <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign count_o = q.cnt;
  assign busy_o = (q.st == CHSH_HO_RUN);
  assign fire_o = q.fire;

  // ***************************************************************
  // Checks.
  // ***************************************************************
  sequence s_arm;
    (q.st == CHSH_HO_IDLE) && trig_i && (q.cnt > CNT_W'(1));
  endsequence

  sequence s_expire;
    (q.st == CHSH_HO_RUN) && (q.cnt == CNT_W'(1));
  endsequence

  chk_arm_starts_run: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_arm |=> busy_o && (q.cnt == $past(q.cnt)) && !fire_o)
    else $error("Armed counter did not start counting.");

  chk_count_step_down: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    busy_o && (q.cnt > CNT_W'(1)) |=> q.cnt == $past(q.cnt) - CNT_W'(1))
    else $error("Hold-off counter did not step down by one.");

  chk_fire_at_one: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_expire |=> fire_o && !busy_o ##1 (!fire_o || $past(trig_i)))
    else $error("Counter did not fire once at a count of one.");

  chk_idle_after_fire: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    fire_o && !trig_i |=> !busy_o && !fire_o)
    else $error("Counter did not stay idle after firing.");

endmodule // chsh_holdoff
`default_nettype wire

// >>> chsh_sync.sv
// Channel start, NCO frequency and NCO phase synchronisation with hold-off counters.
`timescale 1ns/1ps
`default_nettype none
module chsh_sync #(
  parameter int NUM_CH = 4  // Number of channels served.
) (
  input wire logic clk_i,                                        // Master clock, 40 MHz.
  input wire logic sys_rst_i,                                    // Asynchronous reset.
  input wire logic ext_sel_i,                                    // Access to external regs.
  input wire logic [chsh_pkg::CHSH_ADDR_W-1:0] addr_i,           // Register address.
  input wire logic [chsh_pkg::CHSH_DATA_W-1:0] wdata_i,          // Write data.
  input wire logic wr_i,                                         // Write strobe, one cycle.
  input wire logic rd_i,                                         // Read strobe, one cycle.
  input wire logic sync_pin_i,                                   // External sync pin.
  output logic [chsh_pkg::CHSH_DATA_W-1:0] rdata_o,              // Read data, next cycle.
  output logic [NUM_CH-1:0] chan_run_o,                          // Channel runs.
  output logic [NUM_CH-1:0][chsh_pkg::CHSH_CTRL_W-1:0] chan_ctrl_o,  // Control bits.
  output logic [NUM_CH-1:0][chsh_pkg::CHSH_DATA_W-1:0] nco_freq_o,   // Active frequency.
  output logic [NUM_CH-1:0] freq_load_o,                         // Frequency load pulse.
  output logic [NUM_CH-1:0][chsh_pkg::CHSH_DATA_W-1:0] nco_phase_o,  // Active phase offset.
  output logic [NUM_CH-1:0] phase_load_o,                        // Phase load pulse.
  output logic [NUM_CH-1:0] phase_clear_o,                       // Accumulator clear pulse.
  output logic [NUM_CH-1:0] mem_we_o,                            // Memory write pulse.
  output logic [6:0] mem_addr_o,                                 // Memory word address.
  output logic [chsh_pkg::CHSH_DATA_W-1:0] mem_wdata_o           // Memory write data.
);
  import chsh_pkg::*;

  // ***************************************************************
  // Parameter check.
  // ***************************************************************
  if (NUM_CH < 1 || NUM_CH > 4) begin : g_chk
    $error("The register map serves one to four channels.");
  end

  // ***************************************************************
  // State of the block, held as one packed struct.
  // ***************************************************************
  typedef struct packed {
    logic [NUM_CH-1:0] sleep;                          // Sleep bits.
    logic [NUM_CH-1:0] prog;                           // Program-mode bits.
    logic [NUM_CH-1:0] sel;                            // Stored trigger selects.
    logic [NUM_CH-1:0][CHSH_CTRL_W-1:0] ctrl;          // Channel control.
    logic [NUM_CH-1:0][CHSH_DATA_W-1:0] freq_shadow;   // Pending frequency.
    logic [NUM_CH-1:0][CHSH_DATA_W-1:0] nco_freq;      // Active frequency.
    logic [NUM_CH-1:0][CHSH_DATA_W-1:0] phase_shadow;  // Pending phase offset.
    logic [NUM_CH-1:0][CHSH_DATA_W-1:0] nco_phase;     // Active phase offset.
    logic [NUM_CH-1:0] freq_load;                      // Frequency load pulse.
    logic [NUM_CH-1:0] phase_load;                     // Phase load pulse.
    logic [NUM_CH-1:0] phase_clear;                    // Accumulator clear pulse.
    logic [NUM_CH-1:0] mem_we;                         // Memory write pulse.
    logic [6:0] mem_addr;                              // Memory word address.
    logic [CHSH_DATA_W-1:0] mem_wdata;                 // Memory write data.
    logic [CHSH_DATA_W-1:0] rdata;                     // Read data.
  } chsh_state_t;

  chsh_state_t q;  // Registered state.
  chsh_state_t d;  // Next state.

  // Hold-off counter signals, indexed by channel then function.
  logic [NUM_CH-1:0][CHSH_NFUNC-1:0] ho_wr;                   // Count writes.
  logic [NUM_CH-1:0][CHSH_NFUNC-1:0] ho_trig;                 // Triggers.
  logic [NUM_CH-1:0][CHSH_NFUNC-1:0] ho_busy;                 // Counting.
  logic [NUM_CH-1:0][CHSH_NFUNC-1:0] ho_fire;                 // Update pulses.
  logic [NUM_CH-1:0][CHSH_NFUNC-1:0][CHSH_CNT_W-1:0] ho_cnt;  // Live counts.
  logic ext_sync_wr;                                          // Write of sync register.

  // True when the address hits offset off of channel ch; page n is channel n-1.
  function automatic logic chan_hit(input logic [CHSH_ADDR_W-1:0] a, input int ch,
                                    input logic [7:0] off);
    chan_hit = (a[11:8] == 4'(ch + 1)) && (a[7:0] == off);
  endfunction

  // ***************************************************************
  // Hold-off counters, three per channel.
  // ***************************************************************
  // One decode of the sync register write serves every counter.
  assign ext_sync_wr = wr_i && ext_sel_i && (addr_i[2:0] == CHSH_EXT_SYNC);

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    for (genvar f = 0; f < CHSH_NFUNC; f++) begin : g_fn
      // Count writes go straight to the counter of that function.
      assign ho_wr[c][f] = wr_i && !ext_sel_i && chan_hit(addr_i, c, chsh_ho_off(f));
      // Soft trigger: command bit and channel select in one write; pin trigger:
      // on-pin bit and pin enable set, pin sampled high.
      // The on-pin bit clears one clock after the fire pulse, so the pin is
      // masked in that clock; a counter left at one would fire again otherwise.
      // A soft sync in that clock is a fresh arm and is let through.
      assign ho_trig[c][f] =
        (ext_sync_wr && wdata_i[CHSH_CMD_POS + f] && wdata_i[CHSH_SEL_POS + c]) ||
        (sync_pin_i && q.ctrl[c][CHSH_CTRL_PIN_EN] &&
         q.ctrl[c][CHSH_CTRL_PIN_POS + f] && !ho_fire[c][f]);

      // Each function of each channel owns one counter.
      chsh_holdoff #(
        .CNT_W(CHSH_CNT_W)
      ) u_ho (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(ho_wr[c][f]),
        .wdata_i(wdata_i),
        .trig_i(ho_trig[c][f]),
        .count_o(ho_cnt[c][f]),
        .busy_o(ho_busy[c][f]),
        .fire_o(ho_fire[c][f])
      );
    end
  end

  // ***************************************************************
  // Next-state logic: register writes, counter effects, then reads.
  // ***************************************************************
  always_comb begin
    d = q;
    d.freq_load = '0;
    d.phase_load = '0;
    d.phase_clear = '0;
    d.mem_we = '0;
    // External register writes.
    if (wr_i && ext_sel_i) begin
      if (addr_i[2:0] == CHSH_EXT_MODE) begin
        // Clearing both bits lets a channel run at once.
        d.sleep = wdata_i[CHSH_SLEEP_POS +: NUM_CH];
        d.prog = wdata_i[CHSH_PROG_POS +: NUM_CH];
      end else if (addr_i[2:0] == CHSH_EXT_SYNC) begin
        // Only the selects are kept; commands act through the counters.
        d.sel = wdata_i[CHSH_SEL_POS +: NUM_CH];
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      // Channel register writes.
      if (wr_i && !ext_sel_i) begin
        // Setting an on-pin bit arms that pin trigger.
        if (chan_hit(addr_i, c, CHSH_OFF_CTRL)) begin
          d.ctrl[c] = wdata_i[CHSH_CTRL_W-1:0];
        end
        if (chan_hit(addr_i, c, CHSH_OFF_FREQ)) begin
          d.freq_shadow[c] = wdata_i;
          // With no hold-off pending the new frequency goes through at once.
          if (ho_cnt[c][1] == '0 && !ho_busy[c][1]) begin
            d.nco_freq[c] = wdata_i;
            d.freq_load[c] = 1'b1;
          end
        end
        // Phase offset follows the frequency rule.
        if (chan_hit(addr_i, c, CHSH_OFF_PHASE)) begin
          d.phase_shadow[c] = wdata_i;
          if (ho_cnt[c][2] == '0 && !ho_busy[c][2]) begin
            d.nco_phase[c] = wdata_i;
            d.phase_load[c] = 1'b1;
          end
        end
        // Memory words are only taken in program mode.
        // All other offsets of a page ignore program mode.
        if (addr_i[11:8] == 4'(c + 1) && addr_i[7] && q.prog[c]) begin
          d.mem_we[c] = 1'b1;
          d.mem_addr = addr_i[6:0];
          d.mem_wdata = wdata_i;
        end
      end
      // Any trigger reaching a channel is a sync event for the phase clear.
      if (|ho_trig[c] && q.ctrl[c][CHSH_CTRL_PCLR]) begin
        d.phase_clear[c] = 1'b1;
      end
      // Counter effects come last so they win over a same-cycle write.
      // A fire also clears its on-pin bit, which disarms the pin.
      if (ho_fire[c][0]) begin
        d.sleep[c] = 1'b0;
        d.ctrl[c][CHSH_CTRL_PIN_POS] = 1'b0;
      end
      if (ho_fire[c][1]) begin
        d.nco_freq[c] = q.freq_shadow[c];
        d.freq_load[c] = 1'b1;
        d.ctrl[c][CHSH_CTRL_PIN_POS + 1] = 1'b0;
      end
      if (ho_fire[c][2]) begin
        d.nco_phase[c] = q.phase_shadow[c];
        d.phase_load[c] = 1'b1;
        d.ctrl[c][CHSH_CTRL_PIN_POS + 2] = 1'b0;
      end
    end
    // Read mux; unmapped addresses read zero.
    // Command bits are not stored and read zero.
    // The read data holds between reads.
    if (rd_i) begin
      d.rdata = '0;
      if (ext_sel_i) begin
        if (addr_i[2:0] == CHSH_EXT_MODE) begin
          d.rdata[CHSH_SLEEP_POS +: NUM_CH] = q.sleep;
          d.rdata[CHSH_PROG_POS +: NUM_CH] = q.prog;
        end else if (addr_i[2:0] == CHSH_EXT_SYNC) begin
          d.rdata[CHSH_SEL_POS +: NUM_CH] = q.sel;
        end
      end else begin
        for (int c = 0; c < NUM_CH; c++) begin
          // Counts read back live, so a countdown can be watched.
          for (int f = 0; f < CHSH_NFUNC; f++) begin
            if (chan_hit(addr_i, c, chsh_ho_off(f))) begin
              d.rdata = ho_cnt[c][f];
            end
          end
          if (chan_hit(addr_i, c, CHSH_OFF_CTRL)) begin
            d.rdata[CHSH_CTRL_W-1:0] = q.ctrl[c];
          end
          if (chan_hit(addr_i, c, CHSH_OFF_FREQ)) begin
            d.rdata = q.freq_shadow[c];
          end
          if (chan_hit(addr_i, c, CHSH_OFF_PHASE)) begin
            d.rdata = q.phase_shadow[c];
          end
        end
      end
    end
  end

  // ***************************************************************
  // State register; reset puts every channel to sleep.
  // ***************************************************************
  // The reset branch loads constants only.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.sleep <= CHSH_RST_SLEEP[NUM_CH-1:0];
      q.prog <= CHSH_RST_PROG[NUM_CH-1:0];
    end else begin
      q <= d;
    end
  end

  // ***************************************************************
  // Outputs.
  // ***************************************************************
  // Data outputs are flip-flops of the state.
  // The run level is one gate over two of them.
  // Load and clear pulses last one clock.
  assign chan_run_o = ~(q.prog | q.sleep);
  assign chan_ctrl_o = q.ctrl;
  assign nco_freq_o = q.nco_freq;
  assign freq_load_o = q.freq_load;
  assign nco_phase_o = q.nco_phase;
  assign phase_load_o = q.phase_load;
  assign phase_clear_o = q.phase_clear;
  assign mem_we_o = q.mem_we;
  assign mem_addr_o = q.mem_addr;
  assign mem_wdata_o = q.mem_wdata;
  assign rdata_o = q.rdata;

  // ***************************************************************
  // Checks per channel.
  // ***************************************************************
  // Each channel is checked on its own.
  // The counters check their own stepping.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chk_ch
    // A frequency write that must go through at once.
    sequence s_freq_now;
      wr_i && !ext_sel_i && chan_hit(addr_i, c, CHSH_OFF_FREQ) &&
      (ho_cnt[c][1] == '0) && !ho_busy[c][1] && !ho_fire[c][1];
    endsequence

    chk_start_wakes: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ho_fire[c][0] |=> !q.sleep[c] && !q.ctrl[c][CHSH_CTRL_PIN_POS])
      else $error("Start fire did not wake the channel.");

    chk_freq_immediate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_freq_now |=> freq_load_o[c] && (nco_freq_o[c] == $past(wdata_i)))
      else $error("Frequency write with zero count was not applied.");

    chk_freq_held: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ho_fire[c][1] && !(wr_i && !ext_sel_i && chan_hit(addr_i, c, CHSH_OFF_FREQ))
      |=> !freq_load_o[c] && $stable(nco_freq_o[c]))
      else $error("Frequency changed without a load.");

    chk_phase_fire: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ho_fire[c][2] |=> phase_load_o[c] && (nco_phase_o[c] == $past(q.phase_shadow[c])))
      else $error("Phase shadow was not loaded at expiry.");

    chk_mem_gated: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      mem_we_o[c] |-> $past(q.prog[c]) && $past(wr_i))
      else $error("Memory written outside program mode.");

    chk_soft_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ext_sync_wr && wdata_i[CHSH_CMD_POS] && wdata_i[CHSH_SEL_POS + c] &&
      !ho_busy[c][0] && (ho_cnt[c][0] > 16'h0001) |=> ho_busy[c][0])
      else $error("Start command did not start the countdown.");

    chk_phase_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      sync_pin_i && q.ctrl[c][CHSH_CTRL_PIN_EN] && q.ctrl[c][CHSH_CTRL_PCLR] &&
      !(|ho_fire[c]) &&
      (|q.ctrl[c][CHSH_CTRL_PIN_POS +: CHSH_NFUNC]) |=> phase_clear_o[c])
      else $error("Sync did not clear the phase accumulator.");

    // A phase write with no hold-off pending reaches the NCO next clock.
    chk_phase_immediate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_i && !ext_sel_i && chan_hit(addr_i, c, CHSH_OFF_PHASE) &&
      (ho_cnt[c][2] == '0) && !ho_busy[c][2] && !ho_fire[c][2]
      |=> phase_load_o[c] && (nco_phase_o[c] == $past(wdata_i)))
      else $error("Phase write with zero count was not applied.");

    // A fired frequency counter does not fire again on the next clock unless a soft sync arrives.
    chk_fire_once: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ho_fire[c][1] && !ext_sync_wr |=> !ho_fire[c][1])
      else $error("Frequency counter fired twice from one sync.");
  end

endmodule // chsh_sync
`default_nettype wire

// >>> chsh_host_model.sv
// Behavioural microprocessor and sync source that drive the register port of the block.
`timescale 1ns/1ps
`default_nettype none
module chsh_host_model (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output logic ext_sel_o,
  output logic [11:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  output logic sync_pin_o
);
  // ************************************************
  // Bus tasks; every change lands on a falling edge.
  // ************************************************
  initial begin
    {ext_sel_o, addr_o, wdata_o, wr_o, rd_o, sync_pin_o} = '0;
  end
  // One write strobe; on release the address and data show the inverse of their last values.
  task automatic wr(input logic ext, input logic [11:0] a, input logic [15:0] d);
    @(negedge clk_i);
    {ext_sel_o, addr_o, wdata_o, wr_o} = {ext, a, d, 1'b1};
    @(negedge clk_i);
    {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
  endtask
  // One read strobe; data is taken one cycle after the strobe.
  task automatic rd(input logic ext, input logic [11:0] a, output logic [15:0] d);
    @(negedge clk_i);
    {ext_sel_o, addr_o, rd_o} = {ext, a, 1'b1};
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
  // One-cycle high level on the sync pin.
  task automatic pulse_sync();
    @(negedge clk_i);
    sync_pin_o = 1'b1;
    @(negedge clk_i);
    sync_pin_o = 1'b0;
  endtask
endmodule // chsh_host_model
`default_nettype wire

// >>> chsh_sync_tb.sv
// Self-checking testbench of the channel update synchronisation block.
`timescale 1ns/1ps
`default_nettype none
module chsh_sync_tb;
  import chsh_pkg::*;
  logic clk_i, sys_rst_i, ext_sel_i, wr_i, rd_i, sync_pin_i;
  logic [11:0] addr_i;
  logic [15:0] wdata_i, rdata_o, rd_val, mem_wdata_o;
  logic [3:0] chan_run_o, freq_load_o, phase_load_o, phase_clear_o, mem_we_o;
  logic [3:0][7:0] chan_ctrl_o;
  logic [3:0][15:0] nco_freq_o, nco_phase_o;
  logic [6:0] mem_addr_o;
  logic [7:0] cnt_off [3] = '{8'h00, 8'h03, 8'h05};
  int num_errors = 0;
  int checks = 0;
  chsh_sync #(.NUM_CH(4)) chsh_sync_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ext_sel_i(ext_sel_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .sync_pin_i(sync_pin_i), .rdata_o(rdata_o), .chan_run_o(chan_run_o),
    .chan_ctrl_o(chan_ctrl_o), .nco_freq_o(nco_freq_o), .freq_load_o(freq_load_o),
    .nco_phase_o(nco_phase_o), .phase_load_o(phase_load_o), .phase_clear_o(phase_clear_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o));
  chsh_host_model chsh_host_model_inst (.clk_i(clk_i), .rdata_i(rdata_o),
    .ext_sel_o(ext_sel_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i),
    .sync_pin_o(sync_pin_i));
  // ************************************************
  // Clock at 40 MHz and a watchdog against hangs.
  // ************************************************
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Observed effect of function f on channel ch.
  function automatic logic [15:0] obs(input int f, input int ch);
    if (f == 0) return {15'h0000, chan_run_o[ch]};
    return (f == 1) ? nco_freq_o[ch] : nco_phase_o[ch];
  endfunction
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ************************************************
  // Main sequence.
  // ************************************************
  initial begin
    sys_rst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk({12'h000, chan_run_o}, 16'h0000);
    chsh_host_model_inst.rd(1'b1, 12'h004, rd_val);
    chk(rd_val, 16'h000F);
    $display("test reset done");
    // Soft triggers of start, hop and beam on channels 1 to 3 in turn.
    for (int f = 0; f < 3; f++) begin
      chsh_host_model_inst.wr(1'b0, {4'(f + 2), cnt_off[f]}, 16'(3 + f));
      if (f > 0) chsh_host_model_inst.wr(1'b0, {4'(f + 2), 8'(2 * f)}, 16'hA5C0 + 16'(f));
      chk(obs(f, f + 1), 16'h0000);
      chsh_host_model_inst.wr(1'b1, 12'h005, 16'(1 << (4 + f)) | 16'(1 << (f + 1)));
      repeat (3 + f) @(negedge clk_i);
      chk(obs(f, f + 1), 16'h0000);
      @(negedge clk_i);
      chk(obs(f, f + 1), (f == 0) ? 16'h0001 : 16'hA5C0 + 16'(f));
      $display("test soft function %0d done", f);
    end
    chsh_host_model_inst.wr(1'b0, 12'h302, 16'h5555);
    repeat (4) @(negedge clk_i);
    chk(nco_freq_o[2], 16'hA5C1);
    // Pin start of channel 0 with phase clear on sync.
    chsh_host_model_inst.wr(1'b0, 12'h100, 16'h0004);
    chsh_host_model_inst.wr(1'b0, 12'h101, 16'h002C);
    chsh_host_model_inst.pulse_sync();
    chk({15'h0000, phase_clear_o[0]}, 16'h0001);
    repeat (4) @(negedge clk_i);
    chk({15'h0000, chan_run_o[0]}, 16'h0000);
    @(negedge clk_i);
    chk({15'h0000, chan_run_o[0]}, 16'h0001);
    chk({8'h00, chan_ctrl_o[0]}, 16'h000C);
    $display("test pin start done");
    // Program mode, memory gating and immediate updates on channel 0.
    chsh_host_model_inst.wr(1'b1, 12'h004, 16'h001F);
    chk({12'h000, chan_run_o}, 16'h0000);
    chsh_host_model_inst.wr(1'b0, 12'h185, 16'h1234);
    chk({11'h000, mem_we_o[0], 4'(mem_addr_o)}, 16'h0015);
    chk(mem_wdata_o, 16'h1234);
    chsh_host_model_inst.wr(1'b1, 12'h005, 16'h0000);
    chsh_host_model_inst.wr(1'b0, 12'h100, 16'h0000);
    chsh_host_model_inst.wr(1'b1, 12'h004, 16'h000E);
    chk({12'h000, chan_run_o}, 16'h0001);
    chsh_host_model_inst.wr(1'b0, 12'h185, 16'h4321);
    chk({15'h0000, mem_we_o[0]}, 16'h0000);
    chsh_host_model_inst.wr(1'b0, 12'h102, 16'h1357);
    chk(nco_freq_o[0], 16'h1357);
    chk({15'h0000, freq_load_o[0]}, 16'h0001);
    chsh_host_model_inst.wr(1'b0, 12'h104, 16'h2468);
    chk(nco_phase_o[0], 16'h2468);
    chk({15'h0000, phase_load_o[0]}, 16'h0001);
    chsh_host_model_inst.rd(1'b0, 12'h106, rd_val);
    chk(rd_val, 16'h0000);
    $display("test program and immediate done");
    // Pin hop and beam on channel 1, which stays asleep.
    chsh_host_model_inst.wr(1'b0, 12'h203, 16'h0003);
    chsh_host_model_inst.wr(1'b0, 12'h205, 16'h0003);
    chsh_host_model_inst.wr(1'b0, 12'h202, 16'h0F0F);
    chsh_host_model_inst.wr(1'b0, 12'h204, 16'h0E0E);
    chsh_host_model_inst.wr(1'b0, 12'h201, 16'h00C8);
    chsh_host_model_inst.pulse_sync();
    repeat (3) @(negedge clk_i);
    chk(nco_freq_o[1], 16'h0000);
    @(negedge clk_i);
    chk(nco_freq_o[1], 16'h0F0F);
    chk(nco_phase_o[1], 16'h0E0E);
    chk({14'h0000, freq_load_o[1], phase_load_o[1]}, 16'h0003);
    chk({8'h00, chan_ctrl_o[1]}, 16'h0008);
    $display("test pin hop and beam done");
    close_out();
  end
endmodule // chsh_sync_tb
`default_nettype wire
